//--- rtl/ddpz_defs.vh
// ddpz_defs.vh: constants for the power-down and calibration block
// assumes inclusion by bare name from rtl and testbench files
`ifndef DDPZ_DEFS_VH
`define DDPZ_DEFS_VH

// command encodings {cs_n, ras_n, cas_n, we_n}
`define DDPZ_CMD_W          4
`define DDPZ_CMD_MRS        4'h0
`define DDPZ_CMD_REF        4'h1
`define DDPZ_CMD_PRE        4'h2
`define DDPZ_CMD_ACT        4'h3
`define DDPZ_CMD_WR         4'h4
`define DDPZ_CMD_RD         4'h5
`define DDPZ_CMD_ZQ         4'h6
`define DDPZ_CMD_NOP        4'h7
`define DDPZ_CS_BIT         3
// address bits
`define DDPZ_ADDR_ZQ_LONG   10
`define DDPZ_ADDR_PPD_DLL   12
`define DDPZ_BA_W           3
// mr select: bank address value for mr0
`define DDPZ_MR0_SEL        3'h0
// timing in link clock cycles and link clock period in ns
`define DDPZ_TCK_NS         800
`define DDPZ_TCPDED_NCK     2'h2
`define DDPZ_TZQINIT_NCK    512
`define DDPZ_TZQOPER_NCK    256
`define DDPZ_TZQCS_NCK      64
`define DDPZ_TBUSY_NCK      4
// counter width
`define DDPZ_CNT_W          10

`endif

//--- rtl/ddpz_sync_edge.v
// ddpz_sync_edge.v: three-stage synchroniser with stable-change detection
// assumes i_async comes from another clock domain or a pin
`timescale 1ns/100ps

module ddpz_sync_edge #(
	parameter RST_VAL = 1'b0
) (
	input  wire i_mclk,
	input  wire i_rst_n,
	input  wire i_async,
	output wire o_level,
	output wire o_rise,
	output wire o_fall
);

reg s1_ff;
reg s2_ff;
reg s3_ff;
reg lvl_ff;
wire nxt_lvl;

// change counted only when stage two and three agree
assign nxt_lvl = (s2_ff == s3_ff) ? s3_ff : lvl_ff;

always @(posedge i_mclk or negedge i_rst_n) begin
	if (!i_rst_n) begin
		s1_ff  <= RST_VAL;
		s2_ff  <= RST_VAL;
		s3_ff  <= RST_VAL;
		lvl_ff <= RST_VAL;
	end else begin
		s1_ff  <= i_async;
		s2_ff  <= s1_ff;
		s3_ff  <= s2_ff;
		lvl_ff <= nxt_lvl;
	end
end

assign o_level = lvl_ff;
assign o_rise  = nxt_lvl & ~lvl_ff;
assign o_fall  = ~nxt_lvl & lvl_ff;

endmodule // ddpz_sync_edge

//--- rtl/ddpz_pd_zq_ctrl.v
// ddpz_pd_zq_ctrl.v: power-down and zq calibration control of the memory device
// assumes ck, cke, reset and command pins arrive asynchronous to i_mclk;
// i_mclk must be well above the link clock rate (10 MHz versus 1.25 MHz)
//
// Notes on behaviour
// - cke low with nop enters power-down
// - running row operation finishes before low power
// - all banks closed gives precharge power-down
// - power-down gates all buffers except ck, odt, cke, reset; odt also dropped in slow-exit precharge power-down
// - command receivers off after tcpded
// - dll off only in slow-exit precharge power-down and in the reset state
// - reset low forces exit to reset state
// - cke high with nop exits power-down
// - first zqcl takes tzqinit, later ones tzqoper
// - zqcl calibrates, then updates driver and termination
// - zqcs completes within tzqcs
`timescale 1ns/100ps
`include "ddpz_defs.vh"

module ddpz_pd_zq_ctrl #(
	parameter NBANK     = 8,
	parameter ZQINIT_CK = `DDPZ_TZQINIT_NCK,
	parameter ZQOPER_CK = `DDPZ_TZQOPER_NCK,
	parameter ZQCS_CK   = `DDPZ_TZQCS_NCK,
	parameter BUSY_CK   = `DDPZ_TBUSY_NCK
) (
	input  wire                   i_mclk,
	input  wire                   i_rst_n,
	input  wire                   i_ck,
	input  wire                   i_cke,
	input  wire                   i_reset_n,
	input  wire                   i_odt,
	input  wire [`DDPZ_CMD_W-1:0] i_cmd,
	input  wire [`DDPZ_BA_W-1:0]  i_ba,
	input  wire                   i_a10,
	input  wire                   i_a12,
	input  wire [NBANK-1:0]       i_bank_busy,
	output wire                   o_pd_active,
	output wire                   o_pd_precharge,
	output wire                   o_pd_low_power,
	output wire                   o_buf_en,
	output wire                   o_cmd_rx_en,
	output wire                   o_dll_on,
	output wire                   o_odt_en,
	output wire                   o_zq_busy,
	output wire                   o_zq_update,
	output wire                   o_in_reset
);

////////////////////////////////////////////////////////////////////////////////
// synchronisers
wire ck_rise;
wire cke_lvl;
wire rstp_lvl;
wire odt_lvl;
wire [`DDPZ_CMD_W-1:0] cmd_lvl;
wire [`DDPZ_BA_W-1:0]  ba_lvl;
wire a10_lvl;
wire a12_lvl;

ddpz_sync_edge #(.RST_VAL(1'b0)) u_ck (
	.i_mclk (i_mclk), .i_rst_n(i_rst_n), .i_async(i_ck),
	.o_level(), .o_rise(ck_rise), .o_fall()
);
ddpz_sync_edge #(.RST_VAL(1'b0)) u_cke (
	.i_mclk (i_mclk), .i_rst_n(i_rst_n), .i_async(i_cke),
	.o_level(cke_lvl), .o_rise(), .o_fall()
);
ddpz_sync_edge #(.RST_VAL(1'b0)) u_rst (
	.i_mclk (i_mclk), .i_rst_n(i_rst_n), .i_async(i_reset_n),
	.o_level(rstp_lvl), .o_rise(), .o_fall()
);
ddpz_sync_edge #(.RST_VAL(1'b0)) u_odt (
	.i_mclk (i_mclk), .i_rst_n(i_rst_n), .i_async(i_odt),
	.o_level(odt_lvl), .o_rise(), .o_fall()
);
ddpz_sync_edge #(.RST_VAL(1'b0)) u_a10 (
	.i_mclk (i_mclk), .i_rst_n(i_rst_n), .i_async(i_a10),
	.o_level(a10_lvl), .o_rise(), .o_fall()
);
ddpz_sync_edge #(.RST_VAL(1'b0)) u_a12 (
	.i_mclk (i_mclk), .i_rst_n(i_rst_n), .i_async(i_a12),
	.o_level(a12_lvl), .o_rise(), .o_fall()
);

// each command flop resets to its nop level, so reset shows no command
localparam [`DDPZ_CMD_W-1:0] CMD_IDLE = `DDPZ_CMD_NOP;

genvar gi;
generate
	for (gi = 0; gi < `DDPZ_CMD_W; gi = gi + 1) begin : g_cmd
		ddpz_sync_edge #(.RST_VAL(CMD_IDLE[gi])) u_c (
			.i_mclk (i_mclk), .i_rst_n(i_rst_n), .i_async(i_cmd[gi]),
			.o_level(cmd_lvl[gi]), .o_rise(), .o_fall()
		);
	end
	for (gi = 0; gi < `DDPZ_BA_W; gi = gi + 1) begin : g_ba
		ddpz_sync_edge #(.RST_VAL(1'b0)) u_b (
			.i_mclk (i_mclk), .i_rst_n(i_rst_n), .i_async(i_ba[gi]),
			.o_level(ba_lvl[gi]), .o_rise(), .o_fall()
		);
	end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// command decode at each sampled link edge
wire is_nop;
wire is_mrs;
wire is_zq;

assign is_nop = cmd_lvl[`DDPZ_CS_BIT] | (cmd_lvl == `DDPZ_CMD_NOP);
assign is_mrs = ~cmd_lvl[`DDPZ_CS_BIT] & (cmd_lvl == `DDPZ_CMD_MRS);
assign is_zq  = ~cmd_lvl[`DDPZ_CS_BIT] & (cmd_lvl == `DDPZ_CMD_ZQ);

////////////////////////////////////////////////////////////////////////////////
// power-down state machine
localparam [4:0] ST_RESET = 5'h01;
localparam [4:0] ST_IDLE  = 5'h02;
localparam [4:0] ST_PD    = 5'h04;
localparam [4:0] ST_ZQ    = 5'h08;
localparam [4:0] ST_SPARE = 5'h10;

reg [4:0]             st_ff;
reg [4:0]             nxt_st;
reg                   pd_act_ff;
reg                   nxt_pd_act;
reg                   a12_ff;
reg                   nxt_a12;
reg                   zq_first_ff;
reg                   nxt_zq_first;
reg [`DDPZ_CNT_W-1:0] cnt_ff;
reg [`DDPZ_CNT_W-1:0] nxt_cnt;
reg [1:0]             cped_ff;
reg [1:0]             nxt_cped;
reg                   zq_upd_ff;
reg                   nxt_zq_upd;
reg                   lowp_ff;
reg                   nxt_lowp;

wire any_busy;
wire banks_open;

// bank activity and busy tracking come from the array core
assign any_busy   = |i_bank_busy;
assign banks_open = pd_act_ff;

always @* begin
	nxt_st       = st_ff;
	nxt_pd_act   = pd_act_ff;
	nxt_a12      = a12_ff;
	nxt_zq_first = zq_first_ff;
	nxt_cnt      = cnt_ff;
	nxt_cped     = cped_ff;
	nxt_zq_upd   = 1'b0;
	nxt_lowp     = lowp_ff;
	case (st_ff)
	ST_RESET: begin
		nxt_zq_first = 1'b1;
		nxt_lowp     = 1'b0;
		if (rstp_lvl && ck_rise)
			nxt_st = ST_IDLE;
	end
	ST_IDLE: begin
		if (ck_rise) begin
			if (is_mrs && ba_lvl == `DDPZ_MR0_SEL)
				nxt_a12 = a12_lvl;
			if (!cke_lvl && is_nop) begin
				nxt_st     = ST_PD;
				// state chosen at entry from the bank busy flags, then held
				nxt_pd_act = any_busy;
				nxt_cped   = `DDPZ_TCPDED_NCK;
				nxt_lowp   = 1'b0;
			end else if (cke_lvl && is_zq) begin
				nxt_st = ST_ZQ;
				if (!a10_lvl)
					nxt_cnt = ZQCS_CK[`DDPZ_CNT_W-1:0];
				else if (zq_first_ff)
					nxt_cnt = ZQINIT_CK[`DDPZ_CNT_W-1:0];
				else
					nxt_cnt = ZQOPER_CK[`DDPZ_CNT_W-1:0];
				nxt_zq_first = zq_first_ff & ~a10_lvl;
			end
		end
	end
	ST_PD: begin
		if (ck_rise) begin
			if (cped_ff != 2'h0)
				nxt_cped = cped_ff - 2'h1;
			// low-power limit applies only once operations finish
			if (!any_busy)
				nxt_lowp = 1'b1;
			if (cke_lvl && is_nop) begin
				nxt_st   = ST_IDLE;
				nxt_lowp = 1'b0;
			end
		end
	end
	ST_ZQ: begin
		if (ck_rise) begin
			if (cnt_ff <= 10'h001) begin
				nxt_st     = ST_IDLE;
				nxt_cnt    = 10'h000;
				nxt_zq_upd = 1'b1;
			end else begin
				nxt_cnt = cnt_ff - 10'h001;
			end
		end
	end
	default: begin
		nxt_st = ST_RESET;
	end
	endcase
	// reset pin overrides every state, power-down included
	if (!rstp_lvl) begin
		nxt_st   = ST_RESET;
		nxt_lowp = 1'b0;
		nxt_cped = 2'h0;
	end
end

always @(posedge i_mclk or negedge i_rst_n) begin
	if (!i_rst_n) begin
		st_ff       <= ST_RESET;
		pd_act_ff   <= 1'b0;
		a12_ff      <= 1'b0;
		zq_first_ff <= 1'b1;
		cnt_ff      <= 10'h000;
		cped_ff     <= 2'h0;
		zq_upd_ff   <= 1'b0;
		lowp_ff     <= 1'b0;
	end else begin
		st_ff       <= nxt_st;
		pd_act_ff   <= nxt_pd_act;
		a12_ff      <= nxt_a12;
		zq_first_ff <= nxt_zq_first;
		cnt_ff      <= nxt_cnt;
		cped_ff     <= nxt_cped;
		zq_upd_ff   <= nxt_zq_upd;
		lowp_ff     <= nxt_lowp;
	end
end

////////////////////////////////////////////////////////////////////////////////
// outputs
wire in_pd;
wire pre_pd;

assign in_pd  = (st_ff == ST_PD);
assign pre_pd = in_pd & ~banks_open;

assign o_pd_active    = in_pd & banks_open;
assign o_pd_precharge = pre_pd;
assign o_pd_low_power = lowp_ff;
assign o_buf_en       = ~in_pd & (st_ff != ST_RESET);
assign o_cmd_rx_en    = ~(in_pd && cped_ff == 2'h0);
// slow exit only when all banks closed and a12 clear
assign o_dll_on       = (st_ff != ST_RESET) & ~(pre_pd & ~a12_ff);
// odt stays sampled in power-down, dropped when dll is off
assign o_odt_en       = odt_lvl & o_dll_on;
assign o_zq_busy      = (st_ff == ST_ZQ);
assign o_zq_update    = zq_upd_ff;
assign o_in_reset     = (st_ff == ST_RESET);

endmodule // ddpz_pd_zq_ctrl

//--- testbench/ddpz_pd_zq_asserts.sv
// assertions on the power-down and calibration block ports
// bound into every ddpz_pd_zq_ctrl instance below
`timescale 1ns/100ps
module ddpz_pd_zq_chk #(parameter NBANK = 8, parameter ZQINIT_CK = 8) (
	input wire logic             i_mclk,
	input wire logic             i_rst_n,
	input wire logic [NBANK-1:0] i_bank_busy,
	input wire logic             o_pd_active,
	input wire logic             o_pd_precharge,
	input wire logic             o_pd_low_power,
	input wire logic             o_buf_en,
	input wire logic             o_cmd_rx_en,
	input wire logic             o_dll_on,
	input wire logic             o_zq_busy,
	input wire logic             o_zq_update,
	input wire logic             o_in_reset
);
	// eight mclk per link cycle, two link cycles of sync slack
	localparam int ZQ_LIM = (ZQINIT_CK + 2) * 8;
	wire pd = o_pd_active | o_pd_precharge;
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);
	a_pd_one_kind: assert property (!(o_pd_active && o_pd_precharge)) else $error("two pd kinds");
	a_buf_off_pd: assert property (pd |-> !o_buf_en) else $error("buffers on in pd");
	a_rx_off_late: assert property ($rose(pd) |-> o_cmd_rx_en [*8] ##[1:24] !o_cmd_rx_en)
		else $error("receivers gated at wrong time");
	a_dll_active: assert property (o_pd_active |-> o_dll_on) else $error("dll off in active pd");
	a_reset_quiet: assert property (o_in_reset |-> !o_buf_en && !o_dll_on && !pd) else $error("reset");
	a_lp_idle: assert property ($rose(o_pd_low_power) |-> pd && i_bank_busy == '0)
		else $error("low power too early");
	a_zq_done: assert property ($rose(o_zq_busy) |-> ##[1:ZQ_LIM] !o_zq_busy) else $error("zq hangs");
	a_upd_pulse: assert property (o_zq_update |=> !o_zq_update) else $error("update not a pulse");
endmodule // ddpz_pd_zq_chk

bind ddpz_pd_zq_ctrl ddpz_pd_zq_chk #(.NBANK(NBANK), .ZQINIT_CK(ZQINIT_CK)) u_chk (.i_mclk, .i_rst_n,
	.i_bank_busy, .o_pd_active, .o_pd_precharge, .o_pd_low_power, .o_buf_en, .o_cmd_rx_en, .o_dll_on,
	.o_zq_busy, .o_zq_update, .o_in_reset);

//--- testbench/ddpz_ctrl_model.sv
// memory controller model: link clock and command pins
// assumes the bench calls send and hold; pins other than ck move on mclk falls
`timescale 1ns/100ps
`include "ddpz_defs.vh"
module ddpz_ctrl_model #(parameter CKE_CK = 3) (
	input  wire logic  i_mclk,
	output logic       o_ck,
	output logic       o_cke,
	output logic       o_reset_n,
	output logic       o_odt,
	output logic [3:0] o_cmd,
	output logic [2:0] o_ba,
	output logic       o_a10,
	output logic       o_a12
);
	initial begin
		{o_ck, o_cke, o_reset_n, o_odt, o_ba, o_a10, o_a12} = 9'h000;
		o_cmd = `DDPZ_CMD_NOP;
		#13;
		forever #400 o_ck = ~o_ck;
	end
	// pins settle mid-period so the rise never sees them move
	task send(input logic c, input logic r, input logic [3:0] cmd, input logic [2:0] ba, input logic a);
		@(negedge o_ck);
		@(negedge i_mclk);
		{o_cke, o_reset_n, o_cmd, o_ba, o_a10, o_a12} = {c, r, cmd, ba, a, a};
		@(posedge o_ck);
		@(negedge o_ck);
		@(negedge i_mclk);
		o_cmd = `DDPZ_CMD_NOP;
		{o_ba, o_a10, o_a12} = ~{o_ba, o_a10, o_a12};
		repeat (3) @(negedge i_mclk);
	endtask
	// termination level moves alone, then settles through the pin flops
	task set_odt(input logic v);
		@(negedge i_mclk);
		o_odt = v;
		repeat (6) @(negedge i_mclk);
	endtask
	task hold(input logic c);
		repeat (CKE_CK) send(c, 1'b1, `DDPZ_CMD_NOP, 3'h0, 1'b0);
	endtask
endmodule // ddpz_ctrl_model

//--- testbench/testbench.sv
// self-checking bench for ddpz_pd_zq_ctrl
// assumes model and checker are compiled first
`timescale 1ns/100ps
`include "ddpz_defs.vh"
module testbench;
	logic       i_mclk = 1'b0;
	logic       i_rst_n = 1'b0;
	logic [7:0] i_bank_busy = 8'h00;
	wire        ck, cke, rst_n_pin, odt, a10, a12;
	wire  [3:0] cmd;
	wire  [2:0] ba;
	wire        pd_act, pd_pre, lp, buf_en, rx_en, dll, odt_en, zq_busy, zq_upd, in_rst;
	int         bad_count = 0;
	int         n_compared = 0;
	int         cyc = 0;
	int         n_upd = 0;

	ddpz_ctrl_model m (.i_mclk(i_mclk), .o_ck(ck), .o_cke(cke), .o_reset_n(rst_n_pin), .o_odt(odt),
		.o_cmd(cmd), .o_ba(ba), .o_a10(a10), .o_a12(a12));
	ddpz_pd_zq_ctrl #(.ZQINIT_CK(8), .ZQOPER_CK(6), .ZQCS_CK(4)) uut (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
		.i_ck(ck), .i_cke(cke), .i_reset_n(rst_n_pin), .i_odt(odt), .i_cmd(cmd), .i_ba(ba), .i_a10(a10),
		.i_a12(a12), .i_bank_busy(i_bank_busy), .o_pd_active(pd_act), .o_pd_precharge(pd_pre),
		.o_pd_low_power(lp), .o_buf_en(buf_en), .o_cmd_rx_en(rx_en), .o_dll_on(dll), .o_odt_en(odt_en),
		.o_zq_busy(zq_busy), .o_zq_update(zq_upd), .o_in_reset(in_rst));

	always #50 i_mclk = ~i_mclk;
	always @(posedge i_mclk) begin
		cyc <= cyc + 1;
		if (zq_upd === 1'b1)
			n_upd <= n_upd + 1;
		if (cyc == 20000) begin
			bad_count++;
			give_verdict;
		end
	end
	////////////////////////////////////////////////////////////////
	task chk(input logic seen, input logic exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %b want %b", $time, seen, exp);
		end
	endtask
	task t_reset;
		chk(in_rst, 1'b1);
		chk(buf_en, 1'b0);
		m.hold(1'b1);
		chk(in_rst, 1'b0);
		chk(buf_en, 1'b1);
		$display("reset test done");
	endtask
	// first long run after any reset gets the longest window
	task t_zq(input logic a, input int n);
		int t;
		int u;
		t = 0;
		u = n_upd;
		m.send(1'b1, 1'b1, `DDPZ_CMD_ZQ, 3'h0, a);
		chk(zq_busy, 1'b1);
		while (zq_busy === 1'b1 && t < 2000) begin
			@(negedge i_mclk);
			t++;
		end
		repeat (2) @(negedge i_mclk);
		chk(t > 8 * n - 16 && t < 8 * n + 8, 1'b1);
		chk(n_upd == u + 1, 1'b1);
		$display("calibration test done");
	endtask
	task t_pd(input logic [7:0] busy, input logic a);
		m.send(1'b1, 1'b1, `DDPZ_CMD_MRS, `DDPZ_MR0_SEL, a);
		m.set_odt(1'b1);
		i_bank_busy = busy;
		m.send(1'b0, 1'b1, `DDPZ_CMD_NOP, 3'h0, 1'b0);
		chk(pd_act, busy != 0);
		chk(pd_pre, busy == 0);
		chk(buf_en, 1'b0);
		m.hold(1'b0);
		chk(rx_en, 1'b0);
		chk(dll, busy != 0 || a);
		chk(lp, busy == 0);
		chk(odt_en, busy != 0 || a);
		i_bank_busy = 8'h00;
		m.send(1'b0, 1'b1, `DDPZ_CMD_ZQ, 3'h0, 1'b1);
		chk(lp, 1'b1);
		chk(zq_busy, 1'b0);
		m.send(1'b1, 1'b1, `DDPZ_CMD_NOP, 3'h0, 1'b0);
		chk(pd_act | pd_pre, 1'b0);
		chk(buf_en, 1'b1);
		m.hold(1'b1);
		chk(rx_en & dll, 1'b1);
		chk(odt_en, 1'b1);
		m.send(1'b1, 1'b1, `DDPZ_CMD_REF, 3'h0, 1'b0);
		m.set_odt(1'b0);
		chk(odt_en, 1'b0);
		$display("power-down test done");
	endtask
	task t_pd_reset;
		m.hold(1'b0);
		chk(pd_pre, 1'b1);
		m.send(1'b0, 1'b0, `DDPZ_CMD_NOP, 3'h0, 1'b0);
		chk(in_rst, 1'b1);
		chk(pd_pre, 1'b0);
		m.hold(1'b1);
		chk(in_rst, 1'b0);
		$display("reset in power-down test done");
	endtask
	task give_verdict;
		$display("compared %0d, wrong %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (20) @(negedge i_mclk);
		i_rst_n = 1'b1;
		t_reset;
		t_zq(1'b1, 8);
		t_zq(1'b1, 6);
		t_zq(1'b0, 4);
		t_pd(8'h05, 1'b0);
		t_pd(8'h00, 1'b0);
		t_pd(8'h00, 1'b1);
		t_pd(8'hfa, 1'b1);
		t_pd_reset;
		t_zq(1'b1, 8);
		give_verdict;
	end
endmodule // testbench
